/* File: rtl/sfcd_pkg.sv */
/*
  Shared constants of the serial flash command decoder: opcodes,
  address lengths, command classes and link timing.
  Assumes both ends run on one 100 MHz clock.
*/
package sfcd_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_IDENTITY_READ = 8'h9F;
  localparam logic [7:0] OP_QUAD_IDENTITY_READ = 8'hAF;
  localparam logic [7:0] OP_UNIQUE_ID_READ = 8'h4B;
  localparam logic [7:0] OP_PARAM_TABLE_READ = 8'h5A;
  localparam logic [7:0] OP_STATUS_ONE_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_TWO_READ = 8'h07;
  localparam logic [7:0] OP_CONFIG_ONE_READ = 8'h35;
  localparam logic [7:0] OP_CONFIG_TWO_READ = 8'h15;
  localparam logic [7:0] OP_CONFIG_THREE_READ = 8'h33;
  localparam logic [7:0] OP_REGISTER_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_ENTER_ADDR32 = 8'hB7;
  localparam logic [7:0] OP_EXIT_ADDR32 = 8'hE9;
  // ==========================================================
  // Command classes
  typedef enum logic [2:0] {
    SFCD_CLS_NONE = 3'h0,
    SFCD_CLS_NOADDR = 3'h1,
    SFCD_CLS_ADDR32 = 3'h2,
    SFCD_CLS_FOLLOW = 3'h3,
    SFCD_CLS_MODE = 3'h4
  } sfcd_class_t;
  // ==========================================================
  // Field widths and timing
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] ADDR_BYTES_SHORT = 3'h3;
  localparam logic [2:0] ADDR_BYTES_LONG = 3'h4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYC = (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;
endpackage

/* File: rtl/sfcd_link_if.sv */
/*
  Link between host SPI controller and flash command decoder.
  Assumes the bench resolves the shared data lines from enables.
*/
`timescale 1ns/1ps
interface sfcd_link_if;
  logic sel_n;      // Chip select, low active
  logic sck;        // Serial clock from host
  logic [3:0] host_dq;    // Host data drive
  logic [3:0] host_dq_oe; // Host drive enables
  logic [3:0] dev_dq;     // Device data drive
  logic [3:0] dev_dq_oe;  // Device drive enables
  logic [3:0] dq;   // Resolved line levels
  // Host end
  modport host (output sel_n, output sck, output host_dq, output host_dq_oe,
    input dev_dq_oe, input dq);
  // Device end
  modport device (input sel_n, input sck, input host_dq_oe, input dq,
    output dev_dq, output dev_dq_oe);
endinterface // sfcd_link_if

/* File: rtl/sfcd_host.sv */
/*
  Host end: frames one command with chip select, shifts opcode and
  optional extra bytes out on line 0, then samples read bytes on line 1.
  Assumes the user waits for BUSY low before each start.
*/
`timescale 1ns/1ps
module sfcd_host (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // User request
  input wire logic START,
  input wire logic [7:0] OPCODE,
  input wire logic [2:0] TX_BYTES,
  input wire logic [31:0] TX_DATA,
  input wire logic [2:0] RX_BYTES,
  output logic BUSY,
  output logic DONE,
  output logic [31:0] RX_DATA,
  // Link
  sfcd_link_if.host LINK
);
  typedef enum logic [1:0] {H_IDLE = 2'h0, H_SHIFT = 2'h1, H_END = 2'h2} sfcd_hst_t;
  sfcd_hst_t st_q;
  logic [3:0] div_q;        // Half period divider
  logic sck_q;              // Serial clock level
  logic [5:0] bits_q;       // Opcode and data bits left to send
  logic [5:0] rx_bits_q;    // Bits to sample
  logic [39:0] sh_q;        // Outbound shift
  logic [31:0] rx_q;
  logic tick;
  logic [1:0] miso_s_q;     // Line 1 synchroniser
  assign tick = (div_q == 4'(sfcd_pkg::LINK_HALF_CYC - 1)); // Slow link rate
  // ==========================================================
  // Divider
  always_ff @(posedge CLOCK) begin
    if (RST || st_q == H_IDLE) begin
      div_q <= 4'h0;
    end else if (tick) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  // Line 1 synchroniser
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      miso_s_q <= 2'h0;
    end else begin
      miso_s_q <= {miso_s_q[0], LINK.dq[1]};
    end
  end
  // ==========================================================
  // Frame sequencer: select low before first rise
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_q <= H_IDLE;
      sck_q <= 1'b0;
      bits_q <= 6'h0;
      rx_bits_q <= 6'h0;
      sh_q <= 40'h0;
      rx_q <= 32'h0;
    end else begin
      case (st_q)
        H_IDLE: begin
          if (START) begin // Whole bytes only
            st_q <= H_SHIFT;
            sh_q <= {OPCODE, TX_DATA};
            bits_q <= 6'({3'h0, TX_BYTES} * 6'h8 + 6'h8);
            rx_bits_q <= 6'({3'h0, RX_BYTES} * 6'h8);
            rx_q <= 32'h0;
          end
        end
        H_SHIFT: begin
          if (tick) begin
            sck_q <= ~sck_q;
            if (sck_q) begin // Falling edge: next bit out
              if (bits_q > 6'h1) begin
                bits_q <= bits_q - 6'h1;
                sh_q <= {sh_q[38:0], 1'b0};
              end else if (bits_q == 6'h1) begin
                bits_q <= 6'h0;
              end
              if (bits_q <= 6'h1 && rx_bits_q == 6'h0) begin
                st_q <= H_END;
              end
            end else if (bits_q == 6'h0 && rx_bits_q != 6'h0) begin
              rx_q <= {rx_q[30:0], miso_s_q[1]};
              rx_bits_q <= rx_bits_q - 6'h1;
            end
          end
        end
        H_END: begin
          if (tick) begin
            st_q <= H_IDLE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end
  // Done pulse and captured data
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      DONE <= 1'b0;
      RX_DATA <= 32'h0;
    end else begin
      DONE <= (st_q == H_END) && tick;
      if ((st_q == H_END) && tick) begin
        RX_DATA <= rx_q;
      end
    end
  end
  assign BUSY = (st_q != H_IDLE);
  // ==========================================================
  // Pins: host drives select, clock, line 0 only
  assign LINK.sel_n = ~(st_q == H_SHIFT);
  assign LINK.sck = sck_q;
  assign LINK.host_dq = {3'h0, sh_q[39]};
  assign LINK.host_dq_oe = {3'h0, (st_q == H_SHIFT) && (bits_q != 6'h0)};
endmodule // sfcd_host

/* File: rtl/sfcd_device.sv */
/*
  Device end: samples select and clock, counts bits, decodes the
  opcode, decides the address length and keeps the address mode bit.
  Assumes host honours mode 0 framing and clock limits.
*/
`timescale 1ns/1ps
// Function
// - Host drives select/clock/input; device drives output
// - Host and device alternate on data lines
// - Host lowers select before first clock rise
// - Select low throughout; raising ends command
// - Reject command ending off a byte boundary
// - 4-byte read opcodes always take four bytes
// - 4-byte program/erase/lock opcodes take four bytes
// - Reset loads address mode from nonvolatile bit
// - Mode bit set: legacy commands take four bytes
// - Legacy reads follow the address mode bit
// - Legacy program/erase/register commands follow mode bit
// - Identification read takes no address bytes
// - Status and config reads take no address
// - Decode register write, write disable, enable
// - Host keeps parameter/unique reads under 133 MHz
// - B7 enters, E9 exits 4-byte addressing
module sfcd_device (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Reset sources and nonvolatile default
  input wire logic SOFT_RESET,
  input wire logic NONVOLATILE_CONFIG_TWO_ALEN,
  // Read data to return
  input wire logic [7:0] READ_BYTE,
  // Decode results
  output logic CMD_VALID,
  output logic [7:0] CMD_OPCODE,
  output logic [2:0] CMD_ADDR_BYTES,
  output logic CMD_DONE,
  output logic CMD_REJECT,
  output logic ADDRESS_LENGTH_BIT,
  output logic WRITE_ENABLE_LATCH,
  output logic REG_WRITE_SEEN,
  // Link
  sfcd_link_if.device LINK
);
  logic [1:0] cs_s_q;       // Select synchroniser
  logic [1:0] ck_s_q;       // Clock synchroniser
  logic [1:0] di_s_q;       // Line 0 synchroniser
  logic ck_d_q;             // Previous synchronised clock
  logic rise;
  logic fall;
  logic sel;
  logic [2:0] bitc_q;       // Bit in byte
  logic [7:0] op_sh_q;      // Opcode shift
  logic have_op_q;
  logic drive_q;            // Device output enable
  logic [7:0] out_sh_q;     // Read data shift
  logic frame_end;
  sfcd_pkg::sfcd_class_t cls;
  assign sel = ~cs_s_q[1];
  assign rise = ck_s_q[1] & ~ck_d_q;
  assign fall = ~ck_s_q[1] & ck_d_q;
  // ==========================================================
  // Synchronisers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cs_s_q <= 2'h3;
      ck_s_q <= 2'h0;
      di_s_q <= 2'h0;
      ck_d_q <= 1'b0;
    end else begin
      cs_s_q <= {cs_s_q[0], LINK.sel_n};
      ck_s_q <= {ck_s_q[0], LINK.sck};
      di_s_q <= {di_s_q[0], LINK.dq[0]};
      ck_d_q <= ck_s_q[1];
    end
  end
  // ==========================================================
  // Opcode classifier
  always_comb begin
    case (op_sh_q)
      8'h13, 8'h0C, 8'h3C, 8'h6C, 8'hBC, 8'hEC, 8'hEE: cls = sfcd_pkg::SFCD_CLS_ADDR32;
      8'h12, 8'h34, 8'h21, 8'h53, 8'hDC, 8'hE0, 8'hE1, 8'hE2, 8'hE3:
        cls = sfcd_pkg::SFCD_CLS_ADDR32;
      8'h5A, 8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'hED:
        cls = sfcd_pkg::SFCD_CLS_FOLLOW;
      8'h02, 8'h32, 8'h20, 8'h52, 8'hD8, 8'h65, 8'h71, 8'h44, 8'h42, 8'h48, 8'h3D, 8'h36,
      8'h39, 8'hFB: cls = sfcd_pkg::SFCD_CLS_FOLLOW;
      sfcd_pkg::OP_IDENTITY_READ, sfcd_pkg::OP_QUAD_IDENTITY_READ,
      sfcd_pkg::OP_UNIQUE_ID_READ: cls = sfcd_pkg::SFCD_CLS_NOADDR;
      sfcd_pkg::OP_STATUS_ONE_READ, sfcd_pkg::OP_STATUS_TWO_READ, sfcd_pkg::OP_CONFIG_ONE_READ,
      sfcd_pkg::OP_CONFIG_TWO_READ, sfcd_pkg::OP_CONFIG_THREE_READ:
        cls = sfcd_pkg::SFCD_CLS_NOADDR;
      sfcd_pkg::OP_REGISTER_WRITE, sfcd_pkg::OP_WRITE_DISABLE,
      sfcd_pkg::OP_WRITE_ENABLE: cls = sfcd_pkg::SFCD_CLS_NOADDR;
      sfcd_pkg::OP_ENTER_ADDR32, sfcd_pkg::OP_EXIT_ADDR32: cls = sfcd_pkg::SFCD_CLS_MODE;
      default: cls = sfcd_pkg::SFCD_CLS_NONE; // Unknown opcode
    endcase
  end
  // ==========================================================
  // Bit counter and opcode capture; select high ends frame
  // Any clocked bit makes a frame, so a cut inside the opcode ends one too
  assign frame_end = ~sel & (have_op_q | (bitc_q != 3'h0));
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      bitc_q <= 3'h0;
      have_op_q <= 1'b0;
      op_sh_q <= 8'h00;
    end else if (!sel) begin // Deselected: restart byte count
      bitc_q <= 3'h0;
      have_op_q <= 1'b0;
    end else if (rise) begin
      bitc_q <= bitc_q + 3'h1;
      if (!have_op_q) begin
        op_sh_q <= {op_sh_q[6:0], di_s_q[1]};
        if (bitc_q == 3'h7) begin
          have_op_q <= 1'b1;
        end
      end
    end
  end
  // Captured opcode cleared on reset
  // Decode pulse after eighth bit
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CMD_VALID <= 1'b0;
      CMD_OPCODE <= 8'h00;
      CMD_ADDR_BYTES <= 3'h0;
    end else begin
      CMD_VALID <= 1'b0;
      if (sel && rise && !have_op_q && bitc_q == 3'h7) begin
        CMD_VALID <= 1'b0;
      end else if (have_op_q && sel && CMD_OPCODE != op_sh_q) begin
        CMD_VALID <= (cls != sfcd_pkg::SFCD_CLS_NONE);
        CMD_OPCODE <= op_sh_q;
        case (cls)
          sfcd_pkg::SFCD_CLS_ADDR32: CMD_ADDR_BYTES <= sfcd_pkg::ADDR_BYTES_LONG;
          sfcd_pkg::SFCD_CLS_FOLLOW: CMD_ADDR_BYTES <= ADDRESS_LENGTH_BIT ?
            sfcd_pkg::ADDR_BYTES_LONG : sfcd_pkg::ADDR_BYTES_SHORT;
          default: CMD_ADDR_BYTES <= 3'h0;
        endcase
      end else if (!have_op_q) begin
        CMD_OPCODE <= 8'h00;
      end
    end
  end
  // ==========================================================
  // Frame end: accept known opcode on byte boundary, else reject
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CMD_DONE <= 1'b0;
      CMD_REJECT <= 1'b0;
    end else begin
      CMD_DONE <= frame_end && have_op_q && bitc_q == 3'h0 &&
        cls != sfcd_pkg::SFCD_CLS_NONE;
      CMD_REJECT <= frame_end &&
        (!have_op_q || bitc_q != 3'h0 || cls == sfcd_pkg::SFCD_CLS_NONE);
    end
  end
  // Address mode bit: reset loads default, B7/E9 change it
  always_ff @(posedge CLOCK) begin
    if (RST || SOFT_RESET) begin
      ADDRESS_LENGTH_BIT <= NONVOLATILE_CONFIG_TWO_ALEN;
    end else if (frame_end && bitc_q == 3'h0) begin
      if (op_sh_q == sfcd_pkg::OP_ENTER_ADDR32) begin
        ADDRESS_LENGTH_BIT <= 1'b1;
      end else if (op_sh_q == sfcd_pkg::OP_EXIT_ADDR32) begin
        ADDRESS_LENGTH_BIT <= 1'b0;
      end
    end
  end
  // Write enable latch and register write marker
  always_ff @(posedge CLOCK) begin
    if (RST || SOFT_RESET) begin
      WRITE_ENABLE_LATCH <= 1'b0;
      REG_WRITE_SEEN <= 1'b0;
    end else begin
      REG_WRITE_SEEN <= frame_end && bitc_q == 3'h0 && op_sh_q == sfcd_pkg::OP_REGISTER_WRITE;
      if (frame_end && bitc_q == 3'h0) begin
        if (op_sh_q == sfcd_pkg::OP_WRITE_ENABLE) begin
          WRITE_ENABLE_LATCH <= 1'b1;
        end else if (op_sh_q == sfcd_pkg::OP_WRITE_DISABLE) begin
          WRITE_ENABLE_LATCH <= 1'b0;
        end
      end
    end
  end
  // ==========================================================
  // Read data return on line 1 for no-address reads
  always_ff @(posedge CLOCK) begin
    if (RST || !sel) begin
      drive_q <= 1'b0;
      out_sh_q <= 8'h00;
    end else if (fall && have_op_q && !drive_q && cls == sfcd_pkg::SFCD_CLS_NOADDR &&
                 op_sh_q != sfcd_pkg::OP_REGISTER_WRITE && op_sh_q != sfcd_pkg::OP_WRITE_ENABLE &&
                 op_sh_q != sfcd_pkg::OP_WRITE_DISABLE) begin
      drive_q <= 1'b1; // Unknown opcodes never drive
      out_sh_q <= READ_BYTE;
    end else if (fall && drive_q) begin
      out_sh_q <= {out_sh_q[6:0], out_sh_q[7]};
    end
  end
  assign LINK.dev_dq = {2'h0, out_sh_q[7], 1'b0};
  assign LINK.dev_dq_oe = {2'h0, drive_q, 1'b0};
endmodule // sfcd_device

/* File: bench/sfcd_link_asserts.sv */
/*
  Checker of the joined link: framing, lane use and turnaround.
  Assumes the bench instantiates it beside the host-device interface.
*/
`timescale 1ns/1ps
module sfcd_link_asserts (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Link signals
  input wire logic sel_n,
  input wire logic sck,
  input wire logic [3:0] host_dq,
  input wire logic [3:0] host_dq_oe,
  input wire logic [3:0] dev_dq,
  input wire logic [3:0] dev_dq_oe
);
  // ==========================================================
  // Helper: clock rises counted modulo a byte
  logic sck_q; // Last sampled link clock
  logic [2:0] bits_q; // Rises in the current frame
  // Track the link clock level
  always_ff @(posedge CLOCK) begin
    sck_q <= RST ? 1'h0 : sck;
  end
  // Count rises while selected, clear when idle
  always_ff @(posedge CLOCK) begin
    if (RST || sel_n) begin
      bits_q <= 3'h0;
    end else if (sck && !sck_q) begin
      bits_q <= bits_q + 3'h1;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // ==========================================================
  // Assertions
  chk_sel_first: assert property ($rose(sck) |-> !sel_n && !$past(sel_n))
    else $error("link clock rose without settled select");
  chk_idle_clock: assert property (sel_n |-> !sck)
    else $error("link clock high outside a frame");
  chk_host_lane: assert property (host_dq_oe[3:1] == 3'h0)
    else $error("host drives a lane other than line 0");
  chk_dev_lane: assert property ({dev_dq_oe[3:2], dev_dq_oe[0]} == 3'h0)
    else $error("device drives a lane other than line 1");
  chk_no_clash: assert property ((host_dq_oe & dev_dq_oe) == 4'h0)
    else $error("both ends drive one data line");
  chk_dev_release: assert property (sel_n [*8] |-> dev_dq_oe == 4'h0)
    else $error("device still drives after frame end");
  chk_turn_fall: assert property ($rose(dev_dq_oe[1]) |-> !sck && !sel_n)
    else $error("device turned on outside clock low phase");
  chk_dev_hold: assert property (dev_dq_oe[1] && sck |-> $stable(dev_dq[1]))
    else $error("device data moved while clock high");
  chk_host_hold: assert property (host_dq_oe[0] && sck |-> $stable(host_dq[0]))
    else $error("host data moved while clock high");
  chk_byte_frame: assert property ($rose(sel_n) |-> bits_q == 3'h0)
    else $error("frame ended off a byte boundary");
endmodule // sfcd_link_asserts

/* File: bench/tb.sv */
/*
  Bench: host and device joined on one link; a second device is
  driven bit by bit to cut frames mid byte.
  Assumes the 100 MHz clock and the link timing of the host.
*/
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // Clock, reset, stimulus and observation
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic start = 1'h0;
  logic [7:0] opcode = 8'h00;
  logic [2:0] tx_bytes = 3'h0;
  logic [31:0] tx_data = 32'hA5C31E96;
  logic [2:0] rx_bytes = 3'h0;
  logic soft_reset = 1'h0;
  logic nv_alen = 1'h0;
  logic [7:0] read_byte = 8'h5C;
  logic busy, done, cmd_valid, cmd_done, cmd_reject, alen, wel, reg_wr;
  logic rej_2, alen_2;
  logic [31:0] rx_data;
  logic [7:0] cmd_opcode;
  logic [2:0] cmd_addr_bytes;
  logic seen_valid = 1'h0;
  logic seen_reject = 1'h0;
  logic seen_wr = 1'h0;
  logic seen_done = 1'h0;
  logic [7:0] seen_op = 8'h00;
  logic rej2 = 1'h0;
  logic [2:0] seen_bytes = 3'h0;
  int checked = 0;
  int mismatches = 0;
  logic [7:0] fix4 [15] = '{8'h13, 8'h0C, 8'h3C, 8'h6C, 8'hBC, 8'hEC, 8'hEE, 8'h12,
    8'h34, 8'h21, 8'h53, 8'hDC, 8'hE1, 8'hE2, 8'hE3};
  logic [7:0] fol [22] = '{8'h5A, 8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'hED,
    8'h02, 8'h32, 8'h20, 8'h52, 8'hD8, 8'h65, 8'h71, 8'h44, 8'h42, 8'h48, 8'h3D,
    8'h36, 8'h39, 8'hFB};
  logic [7:0] rdz [8] = '{8'h05, 8'h07, 8'h35, 8'h15, 8'h33, 8'h9F, 8'hAF, 8'h4B};
  sfcd_link_if link ();
  sfcd_link_if link2 ();
  // Clock generator
  always #5 clock = ~clock;
  // Resolve shared lines, pulled up when released
  for (genvar i = 0; i < 4; i++) begin : g_res
    assign link.dq[i] = link.dev_dq_oe[i] ? link.dev_dq[i] :
      (link.host_dq_oe[i] ? link.host_dq[i] : 1'h1);
    assign link2.dq[i] = link2.dev_dq_oe[i] ? link2.dev_dq[i] :
      (link2.host_dq_oe[i] ? link2.host_dq[i] : 1'h1);
  end
  // ==========================================================
  // Design ends and checker
  sfcd_host sfcd_host_i (.CLOCK(clock), .RST(rst), .START(start), .OPCODE(opcode),
    .TX_BYTES(tx_bytes), .TX_DATA(tx_data), .RX_BYTES(rx_bytes), .BUSY(busy),
    .DONE(done), .RX_DATA(rx_data), .LINK(link.host));
  sfcd_device sfcd_device_i (.CLOCK(clock), .RST(rst), .SOFT_RESET(soft_reset),
    .NONVOLATILE_CONFIG_TWO_ALEN(nv_alen), .READ_BYTE(read_byte), .CMD_VALID(cmd_valid),
    .CMD_OPCODE(cmd_opcode), .CMD_ADDR_BYTES(cmd_addr_bytes), .CMD_DONE(cmd_done),
    .CMD_REJECT(cmd_reject), .ADDRESS_LENGTH_BIT(alen), .WRITE_ENABLE_LATCH(wel),
    .REG_WRITE_SEEN(reg_wr), .LINK(link.device));
  sfcd_device sfcd_device_i2 (.CLOCK(clock), .RST(rst), .SOFT_RESET(soft_reset),
    .NONVOLATILE_CONFIG_TWO_ALEN(nv_alen), .READ_BYTE(read_byte), .CMD_VALID(),
    .CMD_OPCODE(), .CMD_ADDR_BYTES(), .CMD_DONE(), .CMD_REJECT(rej_2),
    .ADDRESS_LENGTH_BIT(alen_2), .WRITE_ENABLE_LATCH(), .REG_WRITE_SEEN(),
    .LINK(link2.device));
  sfcd_link_asserts sfcd_link_asserts_i (.CLOCK(clock), .RST(rst), .sel_n(link.sel_n),
    .sck(link.sck), .host_dq(link.host_dq), .host_dq_oe(link.host_dq_oe),
    .dev_dq(link.dev_dq), .dev_dq_oe(link.dev_dq_oe));
  // Latch decoder pulses for the running test
  always @(posedge clock) begin
    if (cmd_valid === 1'h1) begin
      seen_valid <= 1'h1;
      seen_bytes <= cmd_addr_bytes;
      seen_op <= cmd_opcode;
    end
    if (cmd_done === 1'h1) seen_done <= 1'h1;
    if (cmd_reject === 1'h1) seen_reject <= 1'h1;
    if (reg_wr === 1'h1) seen_wr <= 1'h1;
    if (rej_2 === 1'h1) rej2 <= 1'h1;
  end
  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One whole frame through the host, then let frame-end pulses land
  task automatic send(input logic [7:0] op, input logic [2:0] tx, input logic [2:0] rx);
    int n = 0;
    @(posedge clock);
    #1;
    {seen_valid, seen_reject, seen_wr, seen_done} = 4'h0;
    seen_bytes = 3'h7;
    seen_op = 8'h00;
    opcode = op;
    tx_bytes = tx;
    rx_bytes = rx;
    start = 1'h1;
    @(posedge clock);
    #1;
    start = 1'h0;
    check(32'({busy, link.sel_n}), 32'h2);
    while (done !== 1'h1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 2000) mismatches++;
    repeat (12) @(posedge clock);
    #1;
    check(32'({busy, link.sel_n}), 32'h1);
  endtask
  // Decode one opcode and compare valid, address bytes and reject
  task automatic dec(input logic [7:0] op, input logic [2:0] nb);
    send(op, nb, 3'h0);
    check(32'({seen_valid, seen_bytes, seen_reject, seen_done, seen_op}),
      32'({1'h1, nb, 1'h0, 1'h1, op}));
  endtask
  // Frame of n bits on the second link, clock at 125 ns
  task automatic bang(input logic [15:0] bits, input int n);
    @(posedge clock);
    #1;
    rej2 = 1'h0;
    link2.sel_n = 1'h0;
    link2.host_dq_oe = 4'h1;
    for (int i = 0; i < n; i++) begin
      link2.host_dq[0] = bits[15-i];
      #62.5 link2.sck = 1'h1;
      #62.5 link2.sck = 1'h0;
    end
    #62.5 link2.sel_n = 1'h1;
    link2.host_dq_oe = 4'h0;
    repeat (20) @(posedge clock);
  endtask
  // ==========================================================
  // Tests and watchdog
  initial begin
    link2.sel_n = 1'h1;
    link2.sck = 1'h0;
    link2.host_dq = 4'h0;
    link2.host_dq_oe = 4'h0;
    repeat (5) @(posedge clock);
    #1 rst = 1'h0;
    check(32'(alen), 32'h0);
    foreach (fix4[i]) dec(fix4[i], 3'h4);
    foreach (fol[i]) dec(fol[i], 3'h3);
    foreach (rdz[i]) begin
      send(rdz[i], 3'h0, 3'h1);
      check(32'({seen_valid, seen_bytes, seen_done, rx_data[7:0]}),
        32'({1'h1, 3'h0, 1'h1, read_byte}));
    end
    dec(8'h06, 3'h0);
    check(32'(wel), 32'h1);
    dec(8'h04, 3'h0);
    check(32'(wel), 32'h0);
    send(8'h01, 3'h1, 3'h0);
    check(32'(seen_wr), 32'h1);
    $display("test decode in 3-byte mode done");
    send(8'hB7, 3'h0, 3'h0);
    check(32'(alen), 32'h1);
    foreach (fol[i]) dec(fol[i], 3'h4);
    dec(8'h13, 3'h4);
    send(8'hE9, 3'h0, 3'h0);
    check(32'(alen), 32'h0);
    $display("test address mode switch done");
    send(8'h00, 3'h0, 3'h1);
    check(32'({seen_valid, seen_reject, seen_done, rx_data[7:0]}), 32'h2FF);
    $display("test unknown opcode done");
    #1 nv_alen = 1'h1;
    @(posedge clock);
    #1 soft_reset = 1'h1;
    @(posedge clock);
    #1 soft_reset = 1'h0;
    repeat (4) @(posedge clock);
    check(32'({alen, alen_2}), 32'h3);
    #1 nv_alen = 1'h0;
    rst = 1'h1;
    repeat (2) @(posedge clock);
    #1 rst = 1'h0;
    check(32'({alen, alen_2}), 32'h0);
    $display("test reset reload done");
    bang(16'hB700, 12);
    check(32'({rej2, alen_2}), 32'h2);
    bang(16'hB700, 8);
    check(32'({rej2, alen_2}), 32'h1);
    bang(16'hB700, 4);
    check(32'({rej2, alen_2}), 32'h3);
    $display("test cut frame done");
    conclude();
  end
  // Cut a hang short well past the expected run length
  initial begin
    #900000;
    mismatches++;
    conclude();
  end
endmodule // tb
